/* verilog/adsq_defines.vh */
/*
 * Shared constants of the conversion sequencer: clock select codes, divider
 * ratios, sequence lengths and result layout.
 * Assumes one system clock whose period is one oscillator period.
 */
`ifndef ADSQ_DEFINES_VH
`define ADSQ_DEFINES_VH

// Conversion clock select codes.
`define ADSQ_CS_DIV8        2'b00
`define ADSQ_CS_DIV32       2'b01
`define ADSQ_CS_DIV64       2'b10
`define ADSQ_CS_RC          2'b11

// Oscillator periods per bit period for each divided setting.
`define ADSQ_DIV8_COUNT     7'h08
`define ADSQ_DIV32_COUNT    7'h20
`define ADSQ_DIV64_COUNT    7'h40

// One instruction cycle is four oscillator periods.
`define ADSQ_TCY_COUNT      3'h4

// Bit periods of one conversion after the first segment.
`define ADSQ_CONV_TADS      4'hc
// Index of the first resolved bit period and of the last one.
`define ADSQ_FIRST_BIT_TAD  4'h1
`define ADSQ_LAST_BIT_TAD   4'ha
// Bit periods waited after an abort before acquisition restarts.
`define ADSQ_ABORT_TADS     2'h2

// Result layout.
`define ADSQ_RES_BITS       10
`define ADSQ_PAD_BITS       6
`define ADSQ_RES_MSB        4'h9

`endif

/* verilog/adsq_tad_divider.v */
/*
 * Bit period generator: a reloadable divider on the oscillator, or a pass-through
 * of the internal RC oscillator tick when the RC setting is selected.
 * Assumes rc_tick is a one-cycle pulse already synchronous to clock.
 */
`timescale 1ns/1ps
`include "adsq_defines.vh"

module adsq_tad_divider #(
    parameter [6:0] DIV8  = `ADSQ_DIV8_COUNT,
    parameter [6:0] DIV32 = `ADSQ_DIV32_COUNT,
    parameter [6:0] DIV64 = `ADSQ_DIV64_COUNT
) (
    input  wire       clock,
    input  wire       sys_rst,
    input  wire       run,
    input  wire [1:0] clk_sel,
    input  wire       rc_tick,
    output wire       tad_tick
);
    reg  [6:0] div_cnt_reg;
    reg  [6:0] div_load;
    wire       div_tick;

    always @* begin
        case (clk_sel)
            `ADSQ_CS_DIV8:  div_load = DIV8;
            `ADSQ_CS_DIV32: div_load = DIV32;
            default:        div_load = DIV64;
        endcase
    end

    // The count restarts whenever the sequencer is idle, so the first tick
    // lands one full bit period after the start.
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            div_cnt_reg <= 7'h01;
        end else if (!run || div_tick) begin
            div_cnt_reg <= 7'h01;
        end else begin
            div_cnt_reg <= div_cnt_reg + 7'h01;
        end
    end

    assign div_tick = run && (div_cnt_reg == div_load);
    assign tad_tick = (clk_sel == `ADSQ_CS_RC) ? (run && rc_tick) : div_tick;
endmodule

/* verilog/adsq_sequencer.v */
/*
 * Control logic of a 10-bit successive-approximation converter: start, abort
 * and completion sequencing, sleep handling, pin read masking and result
 * justification into a 16-bit register pair.
 * Assumes all control bits arrive as synchronous levels or one-cycle pulses
 * from the register file, and comp_above comes from the analog comparator.
 */
`timescale 1ns/1ps
`include "adsq_defines.vh"

module adsq_sequencer #(
    parameter       NUM_PINS = 16,
    parameter [6:0] DIV8     = `ADSQ_DIV8_COUNT,
    parameter [6:0] DIV32    = `ADSQ_DIV32_COUNT,
    parameter [6:0] DIV64    = `ADSQ_DIV64_COUNT
) (
    input  wire                clock,
    input  wire                sys_rst,
    input  wire                converter_on_bit,
    input  wire                go_set_pulse,
    input  wire                go_clear_pulse,
    input  wire [7:0]          second_converter_control,
    input  wire [3:0]          channel_select_bits,
    input  wire [NUM_PINS-1:0] pin_dir_input,
    input  wire [NUM_PINS-1:0] pin_analog_cfg,
    input  wire [NUM_PINS-1:0] pin_level,
    input  wire                sleep_mode,
    input  wire                conversion_irq_enable,
    input  wire                done_flag_clear,
    input  wire                rc_tick,
    input  wire                comp_above,
    input  wire                result_lo_wr,
    input  wire                result_hi_wr,
    input  wire [7:0]          result_wdata,
    output wire                go_flag,
    output wire                conversion_done_flag,
    output wire                done_pulse,
    output wire                wake_pulse,
    output wire                module_powered,
    output wire                hold_connected,
    output wire                sample_digital_level,
    output wire [3:0]          analog_mux_sel,
    output wire [9:0]          sar_dac,
    output wire [7:0]          result_lo,
    output wire [7:0]          result_hi,
    output wire [NUM_PINS-1:0] port_read
);
    localparam [3:0] ST_IDLE  = 4'b0001;
    localparam [3:0] ST_START = 4'b0010;
    localparam [3:0] ST_CONV  = 4'b0100;
    localparam [3:0] ST_WAIT2 = 4'b1000;

    // State roles:
    // ST_IDLE holds the capacitor on the selected channel, which is acquisition.
    // ST_START is the first segment after go. It lasts at least one instruction
    // cycle and ends on the next bit period tick.
    // ST_CONV counts twelve bit periods and resolves ten result bits.
    // ST_WAIT2 keeps the capacitor off the input until the second bit period tick
    // after an abort, so a half-resolved charge never meets the source.

    wire [1:0] clk_sel;
    wire       result_format_bit;
    wire       tad_tick;
    wire       run;
    wire       sleep_rise;
    wire       abort_req;
    wire       sleep_kill;
    wire       finish;
    wire [9:0] final_code;
    wire [15:0] justified;

    reg [3:0]  state_reg;
    reg [3:0]  state_next;
    reg [2:0]  tcy_cnt_reg;
    reg [3:0]  tad_cnt_reg;
    reg [1:0]  wait_cnt_reg;
    reg        go_reg;
    reg        done_flag_reg;
    reg        powered_off_reg;
    reg        sleep_d_reg;
    reg [9:0]  sar_reg;
    reg [7:0]  result_lo_reg;
    reg [7:0]  result_hi_reg;
    reg        wake_reg;

    assign clk_sel           = second_converter_control[7:6];
    assign result_format_bit = second_converter_control[5];

    assign run = (state_reg != ST_IDLE);

    // The divider is held in reload while idle. This costs nothing in power
    // and makes the first tick land a full bit period after go, which keeps the
    // first segment inside its upper bound without a separate phase counter.

    adsq_tad_divider #(
        .DIV8  (DIV8),
        .DIV32 (DIV32),
        .DIV64 (DIV64)
    ) u_tad (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .run      (run),
        .clk_sel  (clk_sel),
        .rc_tick  (rc_tick),
        .tad_tick (tad_tick)
    );

    // Sleep is seen as a level from the core. Only its rising edge aborts, so
    // a conversion started while already asleep on the RC clock is not killed
    // by the level itself. The delayed copy resets low, matching the awake
    // state, so no false edge follows a reset.
    assign sleep_rise = sleep_mode && !sleep_d_reg;
    // A divided clock stops in sleep, so a running conversion cannot finish.
    assign sleep_kill = sleep_rise && (clk_sel != `ADSQ_CS_RC) && go_reg;
    assign abort_req  = go_clear_pulse && !go_set_pulse && (state_reg == ST_START || state_reg == ST_CONV);
    assign finish     = (state_reg == ST_CONV) && tad_tick &&
                        (tad_cnt_reg == `ADSQ_CONV_TADS - 4'h1);

    // The least significant bit is decided one tick before the load, so the
    // register already holds the whole code when completion fires.
    assign final_code = sar_reg;

    // Next state. Abort and power loss override the normal flow: a power loss
    // or a sleep abort goes straight to idle, since the capacitor has nothing
    // to protect once the converter is off, while a software abort must pass
    // through the two period wait first.
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (go_set_pulse && converter_on_bit && !powered_off_reg) begin
                    state_next = ST_START;
                end
            end
            ST_START: begin
                // Wait at least one instruction cycle, then the next bit period edge.
                if (tcy_cnt_reg >= `ADSQ_TCY_COUNT && tad_tick) begin
                    state_next = ST_CONV;
                end
            end
            ST_CONV: begin
                if (finish) begin
                    state_next = ST_IDLE;
                end
            end
            ST_WAIT2: begin
                if (tad_tick && wait_cnt_reg == `ADSQ_ABORT_TADS - 2'h1) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        if (abort_req) begin
            state_next = ST_WAIT2;
        end
        if (sleep_kill || !converter_on_bit) begin
            state_next = ST_IDLE;
        end
    end

    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Instruction cycle counter for the first segment.
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            tcy_cnt_reg <= 3'h0;
        end else if (state_reg != ST_START) begin
            tcy_cnt_reg <= 3'h1;
        end else if (tcy_cnt_reg < `ADSQ_TCY_COUNT) begin
            tcy_cnt_reg <= tcy_cnt_reg + 3'h1;
        end
    end

    // Bit period counter across the conversion.
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            tad_cnt_reg <= 4'h0;
        end else if (state_reg != ST_CONV) begin
            tad_cnt_reg <= 4'h0;
        end else if (tad_tick) begin
            tad_cnt_reg <= tad_cnt_reg + 4'h1;
        end
    end

    // Bit period counter of the abort wait. It only needs to reach the length
    // of the wait, so two bits suffice.
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wait_cnt_reg <= 2'h0;
        end else if (state_reg != ST_WAIT2) begin
            wait_cnt_reg <= 2'h0;
        end else if (tad_tick) begin
            wait_cnt_reg <= wait_cnt_reg + 2'h1;
        end
    end

    // Successive approximation: the first bit period prepares the MSB trial,
    // each of the next ten periods decides one bit and tries the next lower one, if any.
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sar_reg <= 10'h000;
        end else if (state_reg == ST_START) begin
            sar_reg <= 10'h000;
        end else if (state_reg == ST_CONV && tad_tick) begin
            if (tad_cnt_reg == 4'h0) begin
                sar_reg[`ADSQ_RES_MSB] <= 1'b1;
            end else if (tad_cnt_reg >= `ADSQ_FIRST_BIT_TAD && tad_cnt_reg <= `ADSQ_LAST_BIT_TAD) begin
                if (!comp_above) begin
                    sar_reg[`ADSQ_RES_MSB - (tad_cnt_reg - `ADSQ_FIRST_BIT_TAD)] <= 1'b0;
                end
                if (tad_cnt_reg != `ADSQ_LAST_BIT_TAD) begin
                    sar_reg[`ADSQ_RES_MSB - tad_cnt_reg] <= 1'b1;
                end
            end
        end
    end

    // Go flag: set by software only while powered, cleared by software,
    // by completion, by a sleep abort or by power down. A set in the same
    // cycle as a software clear wins.
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            go_reg <= 1'b0;
        end else if (go_set_pulse && converter_on_bit && !powered_off_reg) begin
            go_reg <= 1'b1;
        end else if (go_clear_pulse || finish || sleep_kill || !converter_on_bit) begin
            go_reg <= 1'b0;
        end
    end

    // Done flag is sticky; a completion in the clearing cycle is kept.
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            done_flag_reg <= 1'b0;
        end else if (finish) begin
            done_flag_reg <= 1'b1;
        end else if (done_flag_clear) begin
            done_flag_reg <= 1'b0;
        end
    end

    // Module power: a sleep abort, or a sleep completion with no wake source,
    // powers the converter off while the on bit stays as software left it.
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            powered_off_reg <= 1'b0;
            sleep_d_reg     <= 1'b0;
            wake_reg        <= 1'b0;
        end else begin
            sleep_d_reg <= sleep_mode;
            wake_reg    <= finish && sleep_mode && conversion_irq_enable;
            if (!sleep_mode) begin
                powered_off_reg <= 1'b0;
            end else if (sleep_kill) begin
                powered_off_reg <= 1'b1;
            end else if (finish && !conversion_irq_enable) begin
                powered_off_reg <= 1'b1;
            end
        end
    end

    // Justification is chosen by the format bit as it stands at completion.
    // Changing the format mid-conversion is therefore harmless, and changing
    // it afterwards does not rearrange a result already loaded.
    assign justified = result_format_bit ? {{`ADSQ_PAD_BITS{1'b0}}, final_code}
                                         : {final_code, {`ADSQ_PAD_BITS{1'b0}}};

    // The result pair has no reset, so it survives every reset untouched.
    always @(posedge clock) begin
        if (finish && converter_on_bit) begin
            result_hi_reg <= justified[15:8];
            result_lo_reg <= justified[7:0];
        end else begin
            if (result_lo_wr) begin
                result_lo_reg <= result_wdata;
            end
            if (result_hi_wr) begin
                result_hi_reg <= result_wdata;
            end
        end
    end

    // Pin side: analog pins read as zero through the port; the selected
    // channel is converted whatever its direction or digital setting, so an
    // output pin presents its own driven level to the sampler.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi = gi + 1) begin : g_pin
            assign port_read[gi] = pin_level[gi] & ~pin_analog_cfg[gi];
        end
    endgenerate

    assign analog_mux_sel       = channel_select_bits;
    assign sample_digital_level = ~pin_dir_input[channel_select_bits];

    // The hold switch closes only in idle with the converter powered. While
    // powered off the switch stays open, so an unpowered converter never loads
    // the source.
    assign hold_connected       = (state_reg == ST_IDLE) && converter_on_bit && !powered_off_reg;
    assign go_flag              = go_reg;
    assign conversion_done_flag = done_flag_reg;
    assign done_pulse           = finish;
    assign wake_pulse           = wake_reg;
    assign module_powered       = converter_on_bit && !powered_off_reg;
    assign sar_dac              = sar_reg;
    assign result_lo            = result_lo_reg;
    assign result_hi            = result_hi_reg;
endmodule

/* test/adsq_analog_model.sv */
/* Behavioural analog source for the sequencer: a hold capacitor and a comparator.
   Assumes sar_dac settles well before the sequencer samples comp_above. */
`timescale 1ns/1ps
module adsq_analog_model (
    input  wire       hold_connected,
    input  wire       sample_digital_level,
    input  wire       pin_high,
    input  wire [9:0] vin,
    input  wire [9:0] sar_dac,
    output logic      comp_above
);
    logic [9:0] held;
    // The capacitor keeps its charge while disconnected, so late input changes are ignored.
    always @* begin
        if (hold_connected)
            held = sample_digital_level ? {10{pin_high}} : vin;
    end
    assign comp_above = (held >= sar_dac);
endmodule

/* test/adsq_seq_checker.sv */
/* Port-level checker of the conversion sequencer.
   Assumes it is bound into adsq_sequencer and sees only its ports. */
`timescale 1ns/1ps
module adsq_seq_checker #(
    parameter       NUM_PINS = 16,
    parameter [6:0] DIV8     = 7'h08
) (
    input wire                clock,
    input wire                sys_rst,
    input wire                converter_on_bit,
    input wire                go_set_pulse,
    input wire                go_clear_pulse,
    input wire [7:0]          second_converter_control,
    input wire [NUM_PINS-1:0] pin_analog_cfg,
    input wire [NUM_PINS-1:0] pin_level,
    input wire                sleep_mode,
    input wire                conversion_irq_enable,
    input wire                result_lo_wr,
    input wire                result_hi_wr,
    input wire                go_flag,
    input wire                conversion_done_flag,
    input wire                done_pulse,
    input wire                wake_pulse,
    input wire                module_powered,
    input wire                hold_connected,
    input wire [7:0]          result_lo,
    input wire [7:0]          result_hi,
    input wire [NUM_PINS-1:0] port_read
);
    reg  [10:0] busy_reg;
    wire [10:0] busy_next = go_flag ? busy_reg + 11'h001 : 11'h000;
    wire        rc_sel    = (second_converter_control[7:6] == 2'b11);
    wire        abort_ev  = go_clear_pulse && !go_set_pulse && !done_pulse && go_flag && converter_on_bit;
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst)
            busy_reg <= 11'h000;
        else
            busy_reg <= busy_next;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    port_mask_a:
        assert property (port_read == (pin_level & ~pin_analog_cfg)) else $error("analog pin reads high");
    start_hold_a:
        assert property (go_set_pulse && converter_on_bit && module_powered && hold_connected && !go_flag
            |=> go_flag && !hold_connected) else $error("start did not disconnect hold");
    min_time_a:
        assert property (done_pulse && !rc_sel |-> busy_reg >= 12 * DIV8) else $error("conversion too short");
    done_seq_a:
        assert property (done_pulse |=> !go_flag && conversion_done_flag) else $error("completion flags wrong");
    abort_wait_a:
        assert property (abort_ev && !rc_sel |=> !go_flag ##0 (!hold_connected)[*8]) else $error("abort wait short");
    abort_keep_a:
        assert property (abort_ev && !result_lo_wr && !result_hi_wr |=> $stable(result_lo) && $stable(result_hi))
            else $error("abort changed result");
    sleep_abort_a:
        assert property ($rose(sleep_mode) && !rc_sel && go_flag |-> ##[1:2] (!go_flag && !module_powered))
            else $error("sleep did not abort");
    wake_a:
        assert property (done_pulse && sleep_mode && conversion_irq_enable |=> wake_pulse) else $error("no wake");
    justify_a:
        assert property (done_pulse |=> (second_converter_control[5] ? result_hi[7:2] : result_lo[5:0]) == 6'h00)
            else $error("pad bits not zero");
    cover property (done_pulse);
    cover property (abort_ev);
    cover property (wake_pulse);
endmodule
bind adsq_sequencer adsq_seq_checker #(.NUM_PINS(NUM_PINS), .DIV8(DIV8)) chk_u (.clock(clock), .sys_rst(sys_rst),
    .converter_on_bit(converter_on_bit), .go_set_pulse(go_set_pulse), .go_clear_pulse(go_clear_pulse),
    .second_converter_control(second_converter_control), .pin_analog_cfg(pin_analog_cfg), .pin_level(pin_level),
    .sleep_mode(sleep_mode), .conversion_irq_enable(conversion_irq_enable), .result_lo_wr(result_lo_wr),
    .result_hi_wr(result_hi_wr), .go_flag(go_flag), .conversion_done_flag(conversion_done_flag),
    .done_pulse(done_pulse), .wake_pulse(wake_pulse), .module_powered(module_powered),
    .hold_connected(hold_connected), .result_lo(result_lo), .result_hi(result_hi), .port_read(port_read));

/* test/adsq_sequencer_test.sv */
/* Self-checking bench of the conversion sequencer with an analog source model.
   Assumes shortened divider ratios 8, 12 and 16 and an RC tick every 7 clocks. */
`timescale 1ns/1ps
module adsq_sequencer_test;
    logic        clock = 0, sys_rst = 1, on = 0, gs = 0, gc = 0, slp = 0;
    logic        irq = 0, dclr = 0, rc = 0, lw = 0, hw = 0, cmp;
    logic [7:0]  ctl2 = 8'h00, wd = 8'h00;
    logic [3:0]  ch = 4'h0, rc_cnt = 4'h0;
    logic [15:0] dir = 16'hffff, an = 16'hffff, lvl = 16'h0000;
    logic [9:0]  vin = 10'h000, v;
    wire  [9:0]  dac;
    wire  [7:0]  rlo, rhi;
    wire  [15:0] prd;
    wire  [3:0]  mux;
    wire         go, dflag, dp, wake, pwr, hold, sdl;
    int          n_fail = 0, n_tests = 0, cycles = 0, t;
    always #25 clock = ~clock;
    always @(posedge clock) begin
        rc_cnt <= (rc_cnt == 4'h6) ? 4'h0 : rc_cnt + 4'h1;
        rc <= (rc_cnt == 4'h6);
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            stop_test;
        end
    end
    adsq_sequencer #(.DIV8(7'h08), .DIV32(7'h0c), .DIV64(7'h10)) dut_u (.clock(clock), .sys_rst(sys_rst),
        .converter_on_bit(on), .go_set_pulse(gs), .go_clear_pulse(gc), .second_converter_control(ctl2),
        .channel_select_bits(ch), .pin_dir_input(dir), .pin_analog_cfg(an), .pin_level(lvl), .sleep_mode(slp),
        .conversion_irq_enable(irq), .done_flag_clear(dclr), .rc_tick(rc), .comp_above(cmp), .result_lo_wr(lw),
        .result_hi_wr(hw), .result_wdata(wd), .go_flag(go), .conversion_done_flag(dflag), .done_pulse(dp),
        .wake_pulse(wake), .module_powered(pwr), .hold_connected(hold), .sample_digital_level(sdl),
        .analog_mux_sel(mux), .sar_dac(dac), .result_lo(rlo), .result_hi(rhi), .port_read(prd));
    adsq_analog_model src_u (.hold_connected(hold), .sample_digital_level(sdl), .pin_high(lvl[ch]),
        .vin(vin), .sar_dac(dac), .comp_above(cmp));
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic start;
        @(posedge clock) gs <= 1'b1;
        @(posedge clock) gs <= 1'b0;
    endtask
    task automatic wait_done;
        t = 0;
        do begin
            @(negedge clock);
            t++;
        end while (dp !== 1'b1 && t < 1200);
    endtask
    task automatic conv(input logic [1:0] s, input logic f, input logic [9:0] x, input logic [15:0] e);
        int n;
        n = (s == 2'b00) ? 8 : (s == 2'b01) ? 12 : (s == 2'b10) ? 16 : 7;
        @(posedge clock);
        ctl2 <= {s, f, 5'h00};
        vin <= x;
        start;
        wait_done;
        chk("time_min", 1'b1, t >= 12 * n);
        chk("time_max", 1'b1, t <= 13 * n + 8);
        step(1);
        chk("result", e, {rhi, rlo});
        chk("go_clear", 1'b0, go);
        chk("done_set", 1'b1, dflag);
        @(posedge clock) dclr <= 1'b1;
        @(posedge clock) dclr <= 1'b0;
    endtask
    task automatic stop_test;
        $display("TB: checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        step(1);
        chk("go_rst", 1'b0, go);
        chk("done_rst", 1'b0, dflag);
        @(posedge clock);
        lw <= 1'b1;
        hw <= 1'b1;
        wd <= 8'h5a;
        @(posedge clock);
        lw <= 1'b0;
        hw <= 1'b0;
        start;
        step(1);
        chk("res_wr", 16'h5a5a, {rhi, rlo});
        chk("go_off", 1'b0, go);
        @(posedge clock) on <= 1'b1;
        step(2);
        for (int k = 0; k < 8; k++) begin
            v = 10'h2b5 ^ (k * 10'h047);
            conv(k[2:1], k[0], v, k[0] ? {6'h00, v} : {v, 6'h00});
        end
        @(posedge clock);
        ch <= 4'h3;
        lvl <= 16'h0f0f;
        an <= 16'h00ff;
        dir <= 16'hfff7;
        step(1);
        chk("port_read", 16'h0f00, prd);
        chk("mux", 16'h0003, mux);
        chk("digital", 1'b1, sdl);
        conv(2'b00, 1'b1, 10'h011, 16'h03ff);
        @(posedge clock);
        dir <= 16'hffff;
        an <= 16'h0000;
        conv(2'b00, 1'b1, 10'h155, 16'h0155);
        start;
        step(40);
        @(posedge clock) gc <= 1'b1;
        @(posedge clock) gc <= 1'b0;
        step(0);
        chk("abort_go", 1'b0, go);
        step(4);
        chk("abort_hold", 1'b0, hold);
        step(28);
        chk("reacquire", 1'b1, hold);
        chk("abort_res", 16'h0155, {rhi, rlo});
        start;
        step(20);
        @(posedge clock) slp <= 1'b1;
        step(3);
        chk("sleep_go", 1'b0, go);
        chk("sleep_pwr", 1'b0, pwr);
        @(posedge clock) slp <= 1'b0;
        step(2);
        chk("pwr_back", 1'b1, pwr);
        for (int k = 1; k >= 0; k--) begin
            @(posedge clock);
            irq <= k[0];
            ctl2 <= 8'he0;
            start;
            slp <= 1'b1;
            wait_done;
            step(1);
            chk("wake", k[0], wake);
            chk("rc_pwr", k[0], pwr);
            chk("rc_res", 16'h0155, {rhi, rlo});
            @(posedge clock) slp <= 1'b0;
        end
        @(posedge clock) ctl2 <= 8'h00;
        start;
        step(30);
        @(posedge clock) sys_rst <= 1'b1;
        step(1);
        chk("rst_go", 1'b0, go);
        chk("rst_res", 16'h0155, {rhi, rlo});
        @(posedge clock) sys_rst <= 1'b0;
        step(2);
        stop_test;
    end
endmodule
